// ---- logic/mcg_global_regs.sv ----
// Global machine-check capability and status registers.
// Assumes check events come from logic on the same core clock.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module mcg_global_regs #(
  parameter logic [7:0] BANK_COUNT  = mcg_pkg::BANK_COUNT_DEF,
  parameter logic       CTL_PRESENT = mcg_pkg::CTL_PRESENT_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire mcg_pkg::mcg_reg_req_t req,
  output var  logic [63:0]           rdata,
  input  wire mcg_pkg::mcg_check_t   check,
  output var  logic                  check_exc,
  output var  logic                  shutdown,
  output var  logic                  irq
);

  // Two concerns live here: the read-only capability word, and the
  // machine-check status flags with their interrupt. Check events come
  // from logic on the core clock, so they are used without synchronisers.
  // The global check control register itself lives outside this block.

  // Status flags, one flop each; the register view is built from them.
  logic        st_restart_q;
  logic        st_errptr_q;
  logic        st_inprog_q;
  logic [2:0]  status_bits;

  // Interrupt status (write one to clear) and its mask, same layout.
  logic        irq_chk_q;
  logic        irq_sd_q;
  logic [1:0]  irq_bits;
  logic [1:0]  irq_mk_q;
  logic        irq_pending;

  // Check handling.
  logic        take;
  logic        second;
  logic        sd_event;

  // Register port decode.
  logic        wr_status;
  logic        wr_irq_st;
  logic        wr_irq_mk;
  logic        rd_cap;
  logic        rd_status;
  logic        rd_irq_st;
  logic        rd_irq_mk;
  logic [63:0] cap_word;
  logic [63:0] rd_word;

  // Register map, 64-bit words; bits not listed read zero.
  //   capability  7:0 bank count, 8 control present; read-only
  //   status      0 restart valid, 1 error pointer, 2 in progress
  //   irq status  0 check taken, 1 shutdown; write one to clear
  //   irq mask    same layout as irq status

  // True for a write strobe aimed at the given register.
  function automatic logic wr_hit(
    input mcg_pkg::mcg_reg_req_t r,
    input logic [11:0]           a
  );
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  // True for a read strobe aimed at the given register.
  function automatic logic rd_hit(
    input mcg_pkg::mcg_reg_req_t r,
    input logic [11:0]           a
  );
    return r.rd && (r.addr == a);
  endfunction : rd_hit

  // Zero-extend the status flags to a bus word.
  function automatic logic [63:0] widen_status(
    input logic [2:0] v
  );
    return {61'h0, v};
  endfunction : widen_status

  // Zero-extend a two-bit interrupt register to a bus word.
  function automatic logic [63:0] widen_irq(
    input logic [1:0] v
  );
    return {62'h0, v};
  endfunction : widen_irq

  // Capability word: bank count and control-present flag, rest zero.
  function automatic logic [63:0] cap_value(
    input logic [7:0] count,
    input logic       present
  );
    logic [63:0] w;
    w                              = 64'h0;
    w[mcg_pkg::CAP_COUNT_LSB +: 8] = count;
    w[mcg_pkg::CAP_CTL_PRES]       = present;
    return w;
  endfunction : cap_value

  // Next value of a flag that hardware sets and software also writes.
  // The hardware event wins a tie, so a check is never lost to a write
  // that lands in the same cycle.
  // Used for the status flags and the interrupt flags alike.
  function automatic logic flag_next(
    input logic cur,
    input logic hw_set,
    input logic hw_val,
    input logic sw_wr,
    input logic sw_val
  );
    logic nxt;
    nxt = cur;
    if (hw_set) begin
      nxt = hw_val;
    end else if (sw_wr) begin
      nxt = sw_val;
    end
    return nxt;
  endfunction : flag_next

  // Fixed at build time; writes to the capability register are dropped.
  assign cap_word = cap_value(BANK_COUNT, CTL_PRESENT);

  assign wr_status = wr_hit(req, mcg_pkg::STATUS_ADDR);
  assign wr_irq_st = wr_hit(req, mcg_pkg::IRQ_ST_ADDR);
  assign wr_irq_mk = wr_hit(req, mcg_pkg::IRQ_MK_ADDR);
  assign rd_cap    = rd_hit(req, mcg_pkg::CAP_ADDR);
  assign rd_status = rd_hit(req, mcg_pkg::STATUS_ADDR);
  assign rd_irq_st = rd_hit(req, mcg_pkg::IRQ_ST_ADDR);
  assign rd_irq_mk = rd_hit(req, mcg_pkg::IRQ_MK_ADDR);

  // A shut-down core takes nothing further until reset.
  assign take     = check.valid && !st_inprog_q && !shutdown;
  // A check while one is still in progress shuts the core down instead.
  assign second   = check.valid && st_inprog_q;
  // Only the entry into shutdown raises its interrupt flag.
  assign sd_event = second && !shutdown;

  // Register view of the status flags; reserved bits stay zero.
  always_comb begin
    status_bits                          = mcg_pkg::STATUS_RST;
    status_bits[mcg_pkg::ST_RESTART_BIT] = st_restart_q;
    status_bits[mcg_pkg::ST_ERRPTR_BIT]  = st_errptr_q;
    status_bits[mcg_pkg::ST_INPROG_BIT]  = st_inprog_q;
  end

  // Register view of the interrupt flags.
  always_comb begin
    irq_bits                            = mcg_pkg::IRQ_RST;
    irq_bits[mcg_pkg::IRQ_CHECK_BIT]    = irq_chk_q;
    irq_bits[mcg_pkg::IRQ_SHUTDOWN_BIT] = irq_sd_q;
  end

  // Any unmasked flag asks for the interrupt.
  assign irq_pending = |(irq_bits & irq_mk_q);

  // Restart flag: loaded from the qualifier of every taken check.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_restart_q <= mcg_pkg::STATUS_RST[mcg_pkg::ST_RESTART_BIT];
    end else begin
      st_restart_q <= flag_next(
        st_restart_q,
        take,
        check.restart_pointer_valid,
        wr_status,
        req.wdata[mcg_pkg::ST_RESTART_BIT]
      );
    end
  end

  // Error-pointer flag: same priority as the restart flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_errptr_q <= mcg_pkg::STATUS_RST[mcg_pkg::ST_ERRPTR_BIT];
    end else begin
      st_errptr_q <= flag_next(
        st_errptr_q,
        take,
        check.error_pointer_valid,
        wr_status,
        req.wdata[mcg_pkg::ST_ERRPTR_BIT]
      );
    end
  end

  // In-progress flag: set by every taken check and cleared only by
  // software, so a handler that forgets the clear ends in shutdown on
  // the next check.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_inprog_q <= mcg_pkg::STATUS_RST[mcg_pkg::ST_INPROG_BIT];
    end else begin
      st_inprog_q <= flag_next(
        st_inprog_q,
        take,
        1'b1,
        wr_status,
        req.wdata[mcg_pkg::ST_INPROG_BIT]
      );
    end
  end

  // The exception leaves in the cycle the three status flags change, so
  // a handler never reads stale qualifiers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      check_exc <= 1'b0;
    end else begin
      check_exc <= take;
    end
  end

  // Shutdown is sticky: only reset brings the core back.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else if (second) begin
      shutdown <= 1'b1;
    end
  end

  // Check-taken interrupt flag; a new check beats a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_chk_q <= mcg_pkg::IRQ_RST[mcg_pkg::IRQ_CHECK_BIT];
    end else begin
      irq_chk_q <= flag_next(
        irq_chk_q,
        take,
        1'b1,
        wr_irq_st && req.wdata[mcg_pkg::IRQ_CHECK_BIT],
        1'b0
      );
    end
  end

  // Shutdown interrupt flag; set once, on entry to shutdown.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sd_q <= mcg_pkg::IRQ_RST[mcg_pkg::IRQ_SHUTDOWN_BIT];
    end else begin
      irq_sd_q <= flag_next(
        irq_sd_q,
        sd_event,
        1'b1,
        wr_irq_st && req.wdata[mcg_pkg::IRQ_SHUTDOWN_BIT],
        1'b0
      );
    end
  end

  // Mask: a one lets the matching status flag drive the interrupt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mk_q <= mcg_pkg::IRQ_RST;
    end else if (wr_irq_mk) begin
      irq_mk_q <= req.wdata[1:0];
    end
  end

  // Interrupt lags the flags by one cycle so that it comes from a flop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending;
    end
  end

  // Idle cycles and unmapped addresses read zero.
  always_comb begin
    rd_word = 64'h0;
    if (rd_cap) begin
      rd_word = cap_word;
    end else if (rd_status) begin
      rd_word = widen_status(status_bits);
    end else if (rd_irq_st) begin
      rd_word = widen_irq(irq_bits);
    end else if (rd_irq_mk) begin
      rd_word = widen_irq(irq_mk_q);
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= mcg_pkg::RDATA_RST;
    end else begin
      rdata <= rd_word;
    end
  end

endmodule : mcg_global_regs
`default_nettype wire

// ---- logic/mcg_pkg.sv ----
// Package for the global machine-check register block.
// Assumes a plain register port with 64-bit data and a single core clock.
package mcg_pkg;

  localparam logic [11:0] CAP_ADDR    = 12'h179;
  localparam logic [11:0] STATUS_ADDR = 12'h17a;
  localparam logic [11:0] IRQ_ST_ADDR = 12'h17c;
  localparam logic [11:0] IRQ_MK_ADDR = 12'h17d;

  localparam int CAP_COUNT_LSB   = 0;
  localparam int CAP_CTL_PRES    = 8;
  localparam int ST_RESTART_BIT  = 0;
  localparam int ST_ERRPTR_BIT   = 1;
  localparam int ST_INPROG_BIT   = 2;

  localparam logic [7:0] BANK_COUNT_DEF  = 8'h05;
  localparam logic       CTL_PRESENT_DEF = 1'h1;

  localparam int IRQ_CHECK_BIT    = 0;
  localparam int IRQ_SHUTDOWN_BIT = 1;

  localparam logic [2:0]  STATUS_RST = 3'h0;
  localparam logic [1:0]  IRQ_RST    = 2'h0;
  localparam logic [63:0] RDATA_RST  = 64'h0;

  typedef struct packed {
    logic       valid;
    logic       restart_pointer_valid;
    logic       error_pointer_valid;
  } mcg_check_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [63:0] wdata;
    logic        wr;
    logic        rd;
  } mcg_reg_req_t;

endpackage : mcg_pkg

// ---- dv/mcg_global_regs_sva.sv ----
// Checker for the global machine-check registers.
// Sees only the block's ports; bound to it below.
`timescale 1ns/1ns
`default_nettype none
module mcg_chk #(
  parameter logic [7:0] BANK_COUNT  = mcg_pkg::BANK_COUNT_DEF,
  parameter logic       CTL_PRESENT = mcg_pkg::CTL_PRESENT_DEF
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire mcg_pkg::mcg_reg_req_t req,
  input wire logic [63:0]           rdata,
  input wire mcg_pkg::mcg_check_t   check,
  input wire logic                  check_exc,
  input wire logic                  shutdown,
  input wire logic                  irq
);
  logic ip_q;
  logic ip;
  logic rc;
  logic rs;
  logic tk;
  assign rc = req.rd && req.addr == mcg_pkg::CAP_ADDR;
  assign rs = check_exc && req.rd && req.addr == mcg_pkg::STATUS_ADDR;
  // Port-side copy of the in-progress bit; a taken check beats a write
  assign tk = check.valid && !ip_q && !shutdown;
  assign ip = ip_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ip_q <= 1'h0;
    else if (tk) ip_q <= 1'h1;
    else if (req.wr && req.addr == mcg_pkg::STATUS_ADDR) ip_q <= req.wdata[2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_cap_count: assert property (rc |=> rdata[7:0] == BANK_COUNT)
    else $error("bank count");
  chk_cap_ctl: assert property (rc |=> rdata[8] == CTL_PRESENT)
    else $error("control flag");
  chk_restart_ptr: assert property (rs |=> rdata[0] ==
    $past(check.restart_pointer_valid, 2)) else $error("restart flag");
  chk_error_ptr: assert property (rs |=> rdata[2:1] ==
    {1'h1, $past(check.error_pointer_valid, 2)}) else $error("error flag");
  chk_exc_taken: assert property (check.valid && !ip && !shutdown
    |=> check_exc) else $error("check not taken");
  chk_second_check: assert property (check.valid && ip
    |=> shutdown && !check_exc) else $error("no shutdown");
  chk_exc_cause: assert property (check_exc |->
    $past(check.valid) && !$past(shutdown)) else $error("stray exception");
  cover property (check_exc);
  cover property (shutdown);
  cover property (irq);
endmodule : mcg_chk
bind mcg_global_regs mcg_chk #(.BANK_COUNT(BANK_COUNT),
  .CTL_PRESENT(CTL_PRESENT)) u_chk (.clk(clk), .rst_n(rst_n), .req(req),
  .rdata(rdata), .check(check), .check_exc(check_exc),
  .shutdown(shutdown), .irq(irq));
`default_nettype wire

// ---- dv/mcg_global_regs_test.sv ----
// Directed test of the global machine-check registers.
// Drives the register port and check events itself.
`timescale 1ns/1ns
`default_nettype none
module mcg_global_regs_test;
  logic                  clk = 1'h0;
  logic                  rst_n = 1'h0;
  mcg_pkg::mcg_reg_req_t req = '0;
  mcg_pkg::mcg_check_t   ck = '0;
  logic [63:0]           rdata;
  logic                  exc, sd, irq;
  int                    error_cnt = 0, n_compared = 0;
  logic [63:0]           n_exc = 64'h0;
  mcg_global_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .check(ck), .check_exc(exc), .shutdown(sd), .irq(irq));
  initial forever #5 clk = ~clk;
  // Counts exception pulses; each stands for one cycle
  always @(posedge clk) begin
    if (exc) n_exc <= n_exc + 64'h1;
  end
  task automatic cmp(logic [63:0] g, logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_bit(logic g, logic e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit
  // One access; a pending check pulse ends at its first edge
  task automatic acc(logic w, logic [11:0] a, logic [63:0] d);
    @(posedge clk);
    ck <= '0;
    req <= '{a, d, w, !w};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : acc
  task automatic ev(logic r, logic e);
    @(posedge clk);
    ck <= '{1'h1, r, e};
  endtask : ev
  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    acc(1'h1, mcg_pkg::CAP_ADDR, 64'hffffffffffffffff);
    acc(1'h0, mcg_pkg::CAP_ADDR, 64'h0);
    cmp(rdata, {55'h0, mcg_pkg::CTL_PRESENT_DEF,
      mcg_pkg::BANK_COUNT_DEF});
    acc(1'h0, 12'h17e, 64'h0);
    cmp(rdata, 64'h0);
    acc(1'h1, mcg_pkg::IRQ_MK_ADDR, 64'h1);
    ev(1'h0, 1'h1);
    acc(1'h0, mcg_pkg::STATUS_ADDR, 64'h0);
    cmp(rdata, 64'h6);
    cmp(n_exc, 64'h1);
    cmp_bit(irq, 1'h1);
    acc(1'h1, mcg_pkg::IRQ_ST_ADDR, 64'h1);
    @(posedge clk);
    #1;
    cmp_bit(irq, 1'h0);
    acc(1'h1, mcg_pkg::STATUS_ADDR, 64'h0);
    ev(1'h1, 1'h0);
    acc(1'h0, mcg_pkg::STATUS_ADDR, 64'h0);
    cmp(rdata, 64'h5);
    ev(1'h0, 1'h1);
    acc(1'h0, mcg_pkg::STATUS_ADDR, 64'h0);
    cmp(rdata, 64'h5);
    cmp(n_exc, 64'h2);
    cmp_bit(sd, 1'h1);
    give_verdict();
  end
endmodule : mcg_global_regs_test
`default_nettype wire
